// *** lcp_pkg.sv ***
package lcp_pkg;
  localparam int LCP_LINE_BYTES = 64;
  localparam int LCP_WAYS = 4;
  localparam int LCP_SIZE_SMALL_KB = 32;
  localparam int LCP_SIZE_LARGE_KB = 64;
  localparam int LCP_FETCH_W = 128;
  localparam int LCP_LOAD_W = 128;
  localparam int LCP_STORE_W = 512;
  localparam int LCP_BEATS = 4;
  localparam int LCP_BEAT_W = 2;
  localparam int LCP_IDX_W = 8;
  localparam int LCP_LINE_W = 26;
  localparam int LCP_THR_W = 4;
  localparam int LCP_THREADS = 2;
  localparam int LCP_SYNC_STAGES = 3;
  localparam logic [LCP_IDX_W-1:0] LCP_IDX_RST = 8'h00;
  localparam logic [LCP_THR_W-1:0] LCP_CNT_RST = 4'h0;
  localparam logic [LCP_BEAT_W-1:0] LCP_BEAT_RST = 2'h0;

  typedef enum logic [1:0] {
    LCP_OP_INV_ADDR,
    LCP_OP_INV_SW,
    LCP_OP_CLEAN_SW,
    LCP_OP_NONE
  } lcp_op_t;

  typedef enum logic [1:0] {
    LCP_ST_INVALID,
    LCP_ST_SHARED_CLEAN,
    LCP_ST_UNIQUE_CLEAN,
    LCP_ST_UNIQUE_DIRTY
  } lcp_mesi_t;

  function automatic int lcp_sets(input int size_kb);
    return (size_kb * 1024) / (LCP_LINE_BYTES * LCP_WAYS);
  endfunction
endpackage

// *** lcp_stream_detect.sv ***
`timescale 1ns/1ps
module lcp_stream_detect (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic fill_done,
  input wire logic fill_full,
  input wire logic wr_burst,
  input wire logic wr_full,
  input wire logic wr_cacheable,
  input wire logic [lcp_pkg::LCP_LINE_W-1:0] wr_line,
  input wire logic load_seen,
  input wire logic [lcp_pkg::LCP_LINE_W-1:0] load_line,
  input wire logic [lcp_pkg::LCP_THR_W-1:0] level1_stream_threshold,
  input wire logic [lcp_pkg::LCP_THR_W-1:0] level2_stream_threshold,
  input wire logic [lcp_pkg::LCP_THR_W-1:0] level3_stream_threshold,
  output logic stream_mode,
  output logic l2_stream,
  output logic l3_stream
);
  logic [lcp_pkg::LCP_THR_W-1:0] fill_cnt_reg;
  logic [lcp_pkg::LCP_THR_W-1:0] wr_cnt_reg;
  logic [lcp_pkg::LCP_LINE_W-1:0] wr_line_reg;
  logic stop;

  // Partial cacheable burst or load to the line being written out ends streaming
  assign stop = (wr_burst && wr_cacheable && !wr_full) ||
    (load_seen && stream_mode && load_line == wr_line_reg); // RULE_19

  // Consecutive full-line fills; a fill that was not fully written resets
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      fill_cnt_reg <= lcp_pkg::LCP_CNT_RST;
    else if (stop || (fill_done && !fill_full))
      fill_cnt_reg <= lcp_pkg::LCP_CNT_RST;
    else if (fill_done && !stream_mode)
      fill_cnt_reg <= fill_cnt_reg + 4'h1; // RULE_17
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      stream_mode <= 1'b0;
    else if (stop)
      stream_mode <= 1'b0; // RULE_19
    else if (fill_done && fill_full && fill_cnt_reg + 4'h1 >= level1_stream_threshold)
      stream_mode <= 1'b1; // RULE_17
  end

  // Keeps counting full-line writes once streaming
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      wr_cnt_reg <= lcp_pkg::LCP_CNT_RST;
    else if (stop || !stream_mode)
      wr_cnt_reg <= lcp_pkg::LCP_CNT_RST;
    else if (wr_burst && wr_full && wr_cnt_reg != 4'hf)
      wr_cnt_reg <= wr_cnt_reg + 4'h1; // RULE_20
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      wr_line_reg <= '0;
    else if (wr_burst)
      wr_line_reg <= wr_line;
  end

  assign l2_stream = stream_mode && wr_cnt_reg >= level2_stream_threshold; // RULE_20
  assign l3_stream = l2_stream && wr_cnt_reg >= level3_stream_threshold; // RULE_21
endmodule

// *** lcp_cache_policy.sv ***
`timescale 1ns/1ps
// Behaviour
// (RULE_01) Instruction and data cache sizes chosen separately at build: 32KB or 64KB.
// (RULE_02) Instruction cache has 64-byte lines, 4-way set associative.
// (RULE_03) Data cache has 64-byte lines, 4-way set associative.
// (RULE_04) Instruction fills arrive from level two over 128-bit reads.
// (RULE_05) Load data returns on 128 bits; store data enters on 512 bits.
// (RULE_06) Every miss fill delivers the critical word first, then the rest.
// (RULE_07) Cacheable fetches with instruction cache disabled act as non-cacheable.
// (RULE_08) Fetches to device pages act as non-cacheable normal fetches.
// (RULE_09) Fetch missing instruction cache may probe data cache; allocates only if enabled.
// (RULE_10) Data enable low: loads/stores non-cacheable, fetches skip level-two/three allocation.
// (RULE_11) Data cache maintenance runs regardless of the data enable.
// (RULE_12) One enable governs both level-one data and level-two caches.
// (RULE_13) Invalidate by address cleans a dirty line before invalidating.
// (RULE_14) Set/way invalidate and clean both clean then invalidate; override ignored.
// (RULE_15) Line states are unique dirty, unique clean, shared clean, invalid only.
// (RULE_16) Data cache allocates on read miss and on write miss.
// (RULE_17) Full line written before fill on consecutive fills enters streaming.
// (RULE_18) Streaming: loads normal; store misses write below without a fill.
// (RULE_19) Streaming ends on partial cacheable burst or load to outgoing line.
// (RULE_20) Further full-line writes past a threshold push level two into streaming.
// (RULE_21) Streaming tracked per thread; three thresholds for levels one to three.
// (RULE_22) Caches self-invalidate after reset unless debug recovery state suppresses it.
module lcp_cache_policy #(
  parameter int IC_SIZE_KB = lcp_pkg::LCP_SIZE_SMALL_KB,
  parameter int DC_SIZE_KB = lcp_pkg::LCP_SIZE_SMALL_KB
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic icache_enable,
  input wire logic data_cache_enable_bit,
  input wire logic set_way_invalidate_override,
  input wire logic legacy_set_way_invalidate_override,
  input wire logic debug_recovery_state,
  input wire logic [lcp_pkg::LCP_THR_W-1:0] level1_stream_threshold,
  input wire logic [lcp_pkg::LCP_THR_W-1:0] level2_stream_threshold,
  input wire logic [lcp_pkg::LCP_THR_W-1:0] level3_stream_threshold,
  input wire logic fetch_valid,
  input wire logic fetch_cacheable,
  input wire logic fetch_device,
  input wire logic fetch_ic_hit,
  output logic fetch_noncacheable,
  output logic fetch_dc_lookup,
  output logic fetch_dc_alloc,
  output logic fetch_l2_alloc,
  input wire logic acc_valid,
  input wire logic acc_thread,
  input wire logic acc_store,
  input wire logic acc_cacheable,
  input wire logic acc_hit,
  input wire logic [lcp_pkg::LCP_LINE_W-1:0] acc_line,
  output logic acc_noncacheable,
  output logic acc_alloc,
  output logic acc_write_below,
  input wire logic fill_start,
  input wire logic [lcp_pkg::LCP_BEAT_W-1:0] fill_crit_beat,
  input wire logic fill_beat_valid,
  input wire logic [lcp_pkg::LCP_FETCH_W-1:0] fill_beat_data,
  output logic [lcp_pkg::LCP_BEAT_W-1:0] fill_beat_index,
  output logic fill_busy,
  input wire logic store_valid,
  input wire logic [lcp_pkg::LCP_STORE_W-1:0] store_data,
  input wire logic load_valid,
  input wire logic [lcp_pkg::LCP_BEAT_W-1:0] load_beat,
  output logic [lcp_pkg::LCP_LOAD_W-1:0] load_data,
  input wire logic fill_done,
  input wire logic fill_full,
  input wire logic fill_thread,
  input wire logic wr_burst,
  input wire logic wr_full,
  input wire logic wr_cacheable,
  input wire logic wr_thread,
  input wire logic [lcp_pkg::LCP_LINE_W-1:0] wr_line,
  output logic [lcp_pkg::LCP_THREADS-1:0] stream_mode,
  output logic [lcp_pkg::LCP_THREADS-1:0] l2_stream_req,
  output logic [lcp_pkg::LCP_THREADS-1:0] l3_stream_req,
  input wire logic tag_valid,
  input wire logic tag_unique,
  input wire logic dirty_bit,
  output lcp_pkg::lcp_mesi_t line_state,
  input wire logic mnt_valid,
  input wire lcp_pkg::lcp_op_t mnt_op,
  output logic mnt_ready,
  output logic mnt_clean,
  output logic mnt_invalidate,
  output logic mnt_done,
  output logic init_busy,
  output logic init_ic_wr,
  output logic init_dc_wr,
  output logic [lcp_pkg::LCP_IDX_W-1:0] init_index
);
  // Set counts follow size, line length and way count
  localparam int IC_SETS = lcp_pkg::lcp_sets(IC_SIZE_KB); // RULE_01 RULE_02
  localparam int DC_SETS = lcp_pkg::lcp_sets(DC_SIZE_KB); // RULE_01 RULE_03
  localparam int MAX_SETS = (IC_SETS > DC_SETS) ? IC_SETS : DC_SETS;
  localparam logic [lcp_pkg::LCP_IDX_W:0] IC_LAST = (lcp_pkg::LCP_IDX_W+1)'(IC_SETS - 1);
  localparam logic [lcp_pkg::LCP_IDX_W:0] DC_LAST = (lcp_pkg::LCP_IDX_W+1)'(DC_SETS - 1);
  localparam logic [lcp_pkg::LCP_IDX_W:0] ALL_LAST = (lcp_pkg::LCP_IDX_W+1)'(MAX_SETS - 1);

  typedef enum logic [2:0] {
    LCP_SYNC_WAIT,
    LCP_INIT,
    LCP_IDLE,
    LCP_CLEAN,
    LCP_INVAL,
    LCP_DONE
  } lcp_state_t;

  lcp_state_t state_reg;
  lcp_state_t state_next;
  logic [lcp_pkg::LCP_SYNC_STAGES-1:0] dbg_sync_reg;
  logic [1:0] wait_reg;
  logic [lcp_pkg::LCP_IDX_W:0] idx_reg;
  logic [lcp_pkg::LCP_BEAT_W-1:0] beat_cnt_reg;
  logic [lcp_pkg::LCP_BEAT_W-1:0] crit_reg;
  logic [lcp_pkg::LCP_LOAD_W-1:0] line_buf [lcp_pkg::LCP_BEATS];
  logic cache_on;
  logic streaming;
  logic [lcp_pkg::LCP_THREADS-1:0] fill_ev;
  logic [lcp_pkg::LCP_THREADS-1:0] wr_ev;
  logic [lcp_pkg::LCP_THREADS-1:0] ld_ev;

  function automatic lcp_pkg::lcp_mesi_t mesi_of(input logic v, input logic u, input logic d);
    // Dirty shared has no encoding; a dirty line is always unique
    if (!v)
      return lcp_pkg::LCP_ST_INVALID;
    else if (d)
      return lcp_pkg::LCP_ST_UNIQUE_DIRTY;
    else if (u)
      return lcp_pkg::LCP_ST_UNIQUE_CLEAN;
    else
      return lcp_pkg::LCP_ST_SHARED_CLEAN;
  endfunction

  // Debug recovery state is a power-channel pin: three flops, later two agree
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      dbg_sync_reg <= '0;
    else
      dbg_sync_reg <= {dbg_sync_reg[1:0], debug_recovery_state};
  end

  // Let the synchroniser settle before the strap is judged
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      wait_reg <= 2'h0;
    else if (state_reg == LCP_SYNC_WAIT && wait_reg != 2'h3)
      wait_reg <= wait_reg + 2'h1;
  end

  // One enable for level-one data and level-two; no separate control exists
  assign cache_on = data_cache_enable_bit; // RULE_12

  // Instruction side policy
  always_comb
  begin
    fetch_noncacheable = !fetch_cacheable || fetch_device || !icache_enable; // RULE_07 RULE_08
    fetch_dc_lookup = fetch_valid && icache_enable && !fetch_ic_hit; // RULE_09
    fetch_dc_alloc = fetch_dc_lookup && cache_on && !fetch_noncacheable; // RULE_09
    fetch_l2_alloc = fetch_valid && !fetch_noncacheable && cache_on; // RULE_10
  end

  // Data side policy
  assign streaming = stream_mode[acc_thread];
  always_comb
  begin
    acc_noncacheable = !acc_cacheable || !cache_on; // RULE_10
    acc_alloc = acc_valid && !acc_noncacheable && !acc_hit &&
      (!acc_store || !streaming); // RULE_16 RULE_18
    acc_write_below = acc_valid && acc_store && !acc_hit &&
      (acc_noncacheable || streaming); // RULE_18
  end

  // Fill order: critical beat then wrap through the line
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      beat_cnt_reg <= lcp_pkg::LCP_BEAT_RST;
      crit_reg <= lcp_pkg::LCP_BEAT_RST;
      fill_busy <= 1'b0;
    end
    else if (fill_start)
    begin
      crit_reg <= fill_crit_beat; // RULE_06
      beat_cnt_reg <= lcp_pkg::LCP_BEAT_RST;
      fill_busy <= 1'b1;
    end
    else if (fill_busy && fill_beat_valid)
    begin
      beat_cnt_reg <= beat_cnt_reg + 2'h1;
      if (beat_cnt_reg == 2'h3)
        fill_busy <= 1'b0;
    end
  end
  assign fill_beat_index = crit_reg + beat_cnt_reg; // RULE_06

  // Line buffer: 128-bit fill beats in, whole 512-bit store line in
  always_ff @(posedge clock)
  begin
    if (store_valid)
    begin
      for (int i = 0; i < lcp_pkg::LCP_BEATS; i++)
        line_buf[i] <= store_data[i*lcp_pkg::LCP_LOAD_W +: lcp_pkg::LCP_LOAD_W]; // RULE_05
    end
    else if (fill_busy && fill_beat_valid)
      line_buf[fill_beat_index] <= fill_beat_data; // RULE_04
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      load_data <= '0;
    else if (load_valid)
      load_data <= line_buf[load_beat]; // RULE_05
  end

  // Per-thread streaming detectors
  assign fill_ev = {fill_done && fill_thread, fill_done && !fill_thread};
  assign wr_ev = {wr_burst && wr_thread, wr_burst && !wr_thread};
  assign ld_ev = {acc_valid && !acc_store && acc_thread, acc_valid && !acc_store && !acc_thread};

  for (genvar t = 0; t < lcp_pkg::LCP_THREADS; t++)
  begin : g_thr
    lcp_stream_detect u_det ( // RULE_21
      .clock(clock),
      .rst_b(rst_b),
      .fill_done(fill_ev[t]),
      .fill_full(fill_full),
      .wr_burst(wr_ev[t]),
      .wr_full(wr_full),
      .wr_cacheable(wr_cacheable),
      .wr_line(wr_line),
      .load_seen(ld_ev[t]),
      .load_line(acc_line),
      .level1_stream_threshold(level1_stream_threshold),
      .level2_stream_threshold(level2_stream_threshold),
      .level3_stream_threshold(level3_stream_threshold),
      .stream_mode(stream_mode[t]),
      .l2_stream(l2_stream_req[t]),
      .l3_stream(l3_stream_req[t])
    );
  end

  assign line_state = mesi_of(tag_valid, tag_unique, dirty_bit); // RULE_15

  // Maintenance and reset invalidation sequencer
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      LCP_SYNC_WAIT:
        if (wait_reg == 2'h3)
          state_next = (dbg_sync_reg[2] == dbg_sync_reg[1] && dbg_sync_reg[2]) ? LCP_IDLE : LCP_INIT; // RULE_22
      LCP_INIT:
        if (idx_reg == ALL_LAST)
          state_next = LCP_IDLE;
      LCP_IDLE:
        // Runs with the data enable in any state
        if (mnt_valid && mnt_op != lcp_pkg::LCP_OP_NONE) // RULE_11
        begin
          // Override bits are not consulted: set/way ops always clean first
          if (mnt_op == lcp_pkg::LCP_OP_INV_ADDR && !dirty_bit) // RULE_13
            state_next = LCP_INVAL;
          else
            state_next = LCP_CLEAN; // RULE_13 RULE_14
        end
      LCP_CLEAN:
        state_next = LCP_INVAL;
      LCP_INVAL:
        state_next = LCP_DONE;
      LCP_DONE:
        state_next = LCP_IDLE;
      default:
        state_next = LCP_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      state_reg <= LCP_SYNC_WAIT;
    else
      state_reg <= state_next;
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      idx_reg <= '0;
    else if (state_reg == LCP_INIT)
      idx_reg <= idx_reg + 9'h001; // RULE_22
  end

  assign mnt_ready = state_reg == LCP_IDLE;
  assign mnt_clean = state_reg == LCP_CLEAN;
  assign mnt_invalidate = state_reg == LCP_INVAL;
  assign mnt_done = state_reg == LCP_DONE;
  assign init_busy = state_reg == LCP_SYNC_WAIT || state_reg == LCP_INIT;
  assign init_ic_wr = state_reg == LCP_INIT && idx_reg <= IC_LAST; // RULE_22
  assign init_dc_wr = state_reg == LCP_INIT && idx_reg <= DC_LAST; // RULE_22
  assign init_index = idx_reg[lcp_pkg::LCP_IDX_W-1:0];

  property p_ic_geom;
    @(posedge clock) disable iff (!rst_b)
    init_ic_wr |-> idx_reg < 9'((IC_SIZE_KB * 1024) / 256);
  endproperty
  a_ic_geom: assert property (p_ic_geom) else $error("ic index past set count"); // RULE_01 RULE_02
  property p_dc_geom;
    @(posedge clock) disable iff (!rst_b)
    init_dc_wr |-> idx_reg < 9'((DC_SIZE_KB * 1024) / 256);
  endproperty
  a_dc_geom: assert property (p_dc_geom) else $error("dc index past set count"); // RULE_01 RULE_03
  property p_crit_first;
    @(posedge clock) disable iff (!rst_b)
    fill_start |=> fill_beat_index == $past(fill_crit_beat);
  endproperty
  a_crit_first: assert property (p_crit_first) else $error("fill did not start at critical beat"); // RULE_06
  property p_load_path;
    @(posedge clock) disable iff (!rst_b)
    load_valid && !store_valid && !fill_busy ##1 !store_valid && !fill_busy
      |-> load_data == line_buf[$past(load_beat)];
  endproperty
  a_load_path: assert property (p_load_path) else $error("load data not from line buffer"); // RULE_05
  property p_ic_off;
    @(posedge clock) disable iff (!rst_b)
    (!icache_enable || fetch_device) |-> fetch_noncacheable && !fetch_l2_alloc;
  endproperty
  a_ic_off: assert property (p_ic_off) else $error("fetch cached while disabled or device"); // RULE_07 RULE_08
  property p_dc_alloc;
    @(posedge clock) disable iff (!rst_b)
    fetch_dc_alloc |-> data_cache_enable_bit && icache_enable && !fetch_ic_hit;
  endproperty
  a_dc_alloc: assert property (p_dc_alloc) else $error("fetch allocated data line wrongly"); // RULE_09
  property p_dc_off;
    @(posedge clock) disable iff (!rst_b)
    !data_cache_enable_bit |-> acc_noncacheable && !acc_alloc && !fetch_l2_alloc;
  endproperty
  a_dc_off: assert property (p_dc_off) else $error("cache used with data enable low"); // RULE_10 RULE_12
  property p_clean_then_inv;
    @(posedge clock) disable iff (!rst_b)
    mnt_ready && mnt_valid && (mnt_op == lcp_pkg::LCP_OP_INV_SW || mnt_op == lcp_pkg::LCP_OP_CLEAN_SW ||
      (mnt_op == lcp_pkg::LCP_OP_INV_ADDR && dirty_bit)) |=> mnt_clean ##1 mnt_invalidate ##1 mnt_done;
  endproperty
  a_clean_then_inv: assert property (p_clean_then_inv) else $error("clean not before invalidate"); // RULE_13 RULE_14
  property p_no_shared_dirty;
    @(posedge clock) disable iff (!rst_b)
    tag_valid && dirty_bit |-> line_state == lcp_pkg::LCP_ST_UNIQUE_DIRTY;
  endproperty
  a_no_shared_dirty: assert property (p_no_shared_dirty) else $error("dirty line not unique dirty"); // RULE_15
  property p_stream_store;
    @(posedge clock) disable iff (!rst_b)
    acc_valid && acc_store && !acc_hit && stream_mode[acc_thread] |-> !acc_alloc && acc_write_below;
  endproperty
  a_stream_store: assert property (p_stream_store) else $error("streaming store miss started fill"); // RULE_18
  property p_init_done;
    @(posedge clock) disable iff (!rst_b)
    $rose(state_reg == LCP_INIT) |-> ##[1:300] state_reg == LCP_IDLE;
  endproperty
  a_init_done: assert property (p_init_done) else $error("reset invalidate did not finish"); // RULE_22
endmodule

// *** lcp_l2_model.sv ***
`timescale 1ns/1ps
module lcp_l2_model (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic fill_start,
  input wire logic slow,
  output logic fill_beat_valid,
  output logic [lcp_pkg::LCP_FETCH_W-1:0] fill_beat_data
);
  logic [2:0] left_reg;
  logic [1:0] stall_reg;
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      left_reg <= 3'h0;
      stall_reg <= 2'h0;
      fill_beat_valid <= 1'b0;
      fill_beat_data <= 128'h0;
    end
    else if (fill_start)
    begin
      left_reg <= 3'h4;
      stall_reg <= slow ? 2'h2 : 2'h0;
      fill_beat_valid <= 1'b0;
      fill_beat_data <= ~fill_beat_data;
    end
    else if (left_reg != 3'h0 && stall_reg == 2'h0)
    begin
      // One 128-bit beat a cycle, first one critical
      fill_beat_valid <= 1'b1;
      fill_beat_data <= {4{29'h0b5ea5a5, left_reg}};
      left_reg <= left_reg - 3'h1;
    end
    else
    begin
      // Idle data toggles so a stale beat never looks fresh
      fill_beat_valid <= 1'b0;
      fill_beat_data <= ~fill_beat_data;
      if (stall_reg != 2'h0)
        stall_reg <= stall_reg - 2'h1;
    end
  end
endmodule

// *** testbench.sv ***
`timescale 1ns/1ps
module testbench;
  logic clock = 1'b0;
  logic rst_b, icache_enable, data_cache_enable_bit, set_way_invalidate_override;
  logic legacy_set_way_invalidate_override, debug_recovery_state, fetch_valid, fetch_cacheable;
  logic fetch_device, fetch_ic_hit, acc_valid, acc_thread, acc_store, acc_cacheable, acc_hit;
  logic fill_start, fill_beat_valid, fill_busy, store_valid, load_valid, fill_done, fill_full;
  logic fill_thread, wr_burst, wr_full, wr_cacheable, wr_thread, tag_valid, tag_unique, dirty_bit;
  logic mnt_valid, mnt_ready, mnt_clean, mnt_invalidate, mnt_done, init_busy, init_ic_wr, init_dc_wr;
  logic fetch_noncacheable, fetch_dc_lookup, fetch_dc_alloc, fetch_l2_alloc, slow;
  logic acc_noncacheable, acc_alloc, acc_write_below;
  logic [3:0] level1_stream_threshold, level2_stream_threshold, level3_stream_threshold;
  logic [25:0] acc_line, wr_line;
  logic [1:0] fill_crit_beat, fill_beat_index, load_beat, stream_mode, l2_stream_req, l3_stream_req;
  logic [1:0] exp_idx;
  logic [127:0] fill_beat_data, load_data;
  logic [511:0] store_data;
  logic [7:0] init_index;
  lcp_pkg::lcp_mesi_t line_state;
  lcp_pkg::lcp_op_t mnt_op;
  int bad_count = 0;
  int comparisons = 0;
  int cycles = 0;

  lcp_cache_policy #(.IC_SIZE_KB(32), .DC_SIZE_KB(64)) lcp_cache_policy_inst (
    .clock, .rst_b, .icache_enable, .data_cache_enable_bit, .set_way_invalidate_override,
    .legacy_set_way_invalidate_override, .debug_recovery_state, .level1_stream_threshold,
    .level2_stream_threshold, .level3_stream_threshold, .fetch_valid, .fetch_cacheable, .fetch_device,
    .fetch_ic_hit, .fetch_noncacheable, .fetch_dc_lookup, .fetch_dc_alloc, .fetch_l2_alloc, .acc_valid,
    .acc_thread, .acc_store, .acc_cacheable, .acc_hit, .acc_line, .acc_noncacheable, .acc_alloc,
    .acc_write_below, .fill_start, .fill_crit_beat, .fill_beat_valid, .fill_beat_data, .fill_beat_index,
    .fill_busy, .store_valid, .store_data, .load_valid, .load_beat, .load_data, .fill_done, .fill_full,
    .fill_thread, .wr_burst, .wr_full, .wr_cacheable, .wr_thread, .wr_line, .stream_mode, .l2_stream_req,
    .l3_stream_req, .tag_valid, .tag_unique, .dirty_bit, .line_state, .mnt_valid, .mnt_op, .mnt_ready,
    .mnt_clean, .mnt_invalidate, .mnt_done, .init_busy, .init_ic_wr, .init_dc_wr, .init_index);

  lcp_l2_model lcp_l2_model_inst (.clock, .rst_b, .fill_start, .slow, .fill_beat_valid, .fill_beat_data);

  always #2.5 clock = ~clock;

  task automatic check(input logic [511:0] seen, input logic [511:0] want);
    comparisons++;
    if (seen !== want)
    begin
      bad_count++;
      $display("BAD t=%0t seen=%0h want=%0h", $time, seen, want);
    end
  endtask

  task automatic test_done;
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Hang guard, well above the several hundred cycles the run needs
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      bad_count++;
      test_done();
    end
  end

  always @(posedge clock)
    if (fill_beat_valid && fill_busy)
    begin
      check(fill_beat_index, exp_idx);
      exp_idx = exp_idx + 2'h1;
    end

  function automatic lcp_pkg::lcp_mesi_t exp_state(input logic v, input logic u, input logic d);
    if (!v)
      return lcp_pkg::LCP_ST_INVALID;
    if (d)
      return lcp_pkg::LCP_ST_UNIQUE_DIRTY;
    return u ? lcp_pkg::LCP_ST_UNIQUE_CLEAN : lcp_pkg::LCP_ST_SHARED_CLEAN;
  endfunction

  task automatic do_reset(input logic skip);
    int ni;
    int nd;
    ni = 0;
    nd = 0;
    @(posedge clock);
    rst_b <= 1'b0;
    debug_recovery_state <= skip;
    repeat (3) @(posedge clock);
    #1 check({init_busy, mnt_ready, stream_mode}, 4'h8);
    @(posedge clock);
    rst_b <= 1'b1;
    for (int i = 0; i < 600 && init_busy !== 1'b0; i++)
    begin
      @(posedge clock);
      #1;
      ni += init_ic_wr;
      nd += init_dc_wr;
    end
    // Every set of each cache is walked once, or none when skip holds the walk off
    check(ni, skip ? 0 : 32 * 1024 / (64 * 4));
    check(nd, skip ? 0 : 64 * 1024 / (64 * 4));
    check({init_busy, mnt_ready}, 2'h1);
  endtask

  task automatic maint(input lcp_pkg::lcp_op_t op, input logic dirty);
    logic cl;
    cl = (op != lcp_pkg::LCP_OP_INV_ADDR) | dirty;
    @(posedge clock);
    mnt_valid <= 1'b1;
    mnt_op <= op;
    dirty_bit <= dirty;
    {set_way_invalidate_override, legacy_set_way_invalidate_override} <= 2'($urandom);
    @(posedge clock);
    mnt_valid <= 1'b0;
    mnt_op <= lcp_pkg::LCP_OP_NONE;
    #1 check({mnt_ready, mnt_clean, mnt_invalidate, mnt_done}, {1'b0, cl, !cl, 1'b0});
    @(posedge clock);
    #1 check({mnt_clean, mnt_invalidate, mnt_done}, cl ? 3'h2 : 3'h1);
    if (cl)
    begin
      @(posedge clock);
      #1 check({mnt_clean, mnt_invalidate, mnt_done}, 3'h1);
    end
    @(posedge clock);
    #1 check(mnt_ready, 1'b1);
  endtask

  task automatic load_chk(input logic [1:0] b, input logic [127:0] want);
    @(posedge clock);
    load_valid <= 1'b1;
    load_beat <= b;
    @(posedge clock);
    load_valid <= 1'b0;
    #1 check(load_data, want);
  endtask

  task automatic do_fill(input logic [1:0] crit, input logic s);
    @(posedge clock);
    fill_start <= 1'b1;
    fill_crit_beat <= crit;
    slow <= s;
    exp_idx = crit;
    @(posedge clock);
    fill_start <= 1'b0;
    #1 check(fill_busy, 1'b1);
    for (int i = 0; i < 40 && fill_busy; i++)
      @(posedge clock) #1;
    check({fill_busy, exp_idx}, {1'b0, crit});
    for (int k = 0; k < 4; k++)
      load_chk(crit + 2'(k), {4{29'h0b5ea5a5, 3'(4 - k)}});
  endtask

  task automatic ev(input logic is_wr, input logic th, input logic full, input logic [25:0] line);
    @(posedge clock);
    fill_done <= !is_wr;
    wr_burst <= is_wr;
    {fill_full, wr_full, fill_thread, wr_thread, wr_line} <= {full, full, th, th, line};
    @(posedge clock);
    {fill_done, wr_burst} <= 2'h0;
    #1;
  endtask

  task automatic acc_chk(input logic th, input logic st, input logic [25:0] line, input logic [1:0] want);
    @(posedge clock);
    {acc_valid, acc_cacheable, acc_hit, acc_thread, acc_store, acc_line} <= {3'h6, th, st, line};
    #1 check({acc_alloc, acc_write_below}, want);
  endtask

  initial
  begin
    {rst_b, icache_enable, data_cache_enable_bit, set_way_invalidate_override, slow} = '0;
    {legacy_set_way_invalidate_override, debug_recovery_state, fetch_valid, fetch_cacheable} = '0;
    {fetch_device, fetch_ic_hit, acc_valid, acc_thread, acc_store, acc_cacheable, acc_hit} = '0;
    {fill_start, fill_crit_beat, store_valid, store_data, load_valid, load_beat, fill_done} = '0;
    {fill_full, fill_thread, wr_burst, wr_full, wr_thread, wr_line, acc_line, mnt_valid} = '0;
    {tag_valid, tag_unique, dirty_bit, exp_idx} = '0;
    wr_cacheable = 1'b1;
    mnt_op = lcp_pkg::LCP_OP_NONE;
    level1_stream_threshold = 4'h2;
    level2_stream_threshold = 4'h2;
    level3_stream_threshold = 4'h3;
    void'($urandom(25075));
    do_reset(1'b0);
    repeat (200)
    begin
      @(posedge clock);
      {icache_enable, data_cache_enable_bit, fetch_cacheable, fetch_device, fetch_ic_hit} <= 5'($urandom);
      {acc_thread, acc_store, acc_cacheable, acc_hit, tag_valid, tag_unique, dirty_bit} <= 7'($urandom);
      {fetch_valid, acc_valid} <= 2'($urandom);
      acc_line <= 26'($urandom);
      #1 check(fetch_noncacheable, !fetch_cacheable | fetch_device | !icache_enable);
      check(fetch_dc_lookup, fetch_valid & icache_enable & !fetch_ic_hit);
      check(fetch_dc_alloc, fetch_valid & icache_enable & !fetch_ic_hit & data_cache_enable_bit & fetch_cacheable
        & !fetch_device);
      check(fetch_l2_alloc, fetch_valid & fetch_cacheable & !fetch_device & icache_enable
        & data_cache_enable_bit);
      check(acc_noncacheable, !acc_cacheable | !data_cache_enable_bit);
      check(acc_alloc, acc_valid & acc_cacheable & data_cache_enable_bit & !acc_hit);
      check(acc_write_below, acc_valid & acc_store & !acc_hit & (!acc_cacheable | !data_cache_enable_bit));
      check(line_state, exp_state(tag_valid, tag_unique, dirty_bit));
    end
    // Maintenance with the data enable low must still run
    @(posedge clock);
    {acc_valid, data_cache_enable_bit} <= 2'h0;
    for (int op = 0; op < 3; op++)
      for (int d = 0; d < 2; d++)
        maint(lcp_pkg::lcp_op_t'(op), 1'(d));
    for (int c = 0; c < 4; c++)
      do_fill(2'(c), c[0]);
    @(posedge clock);
    store_valid <= 1'b1;
    for (int i = 0; i < 16; i++)
      store_data[i * 32 +: 32] <= $urandom;
    @(posedge clock);
    store_valid <= 1'b0;
    data_cache_enable_bit <= 1'b1;
    for (int b = 0; b < 4; b++)
      load_chk(2'(b), store_data[b * 128 +: 128]);
    // Streaming entry needs consecutive full fills on one thread
    ev(1'b0, 1'b0, 1'b1, 26'h0);
    ev(1'b0, 1'b0, 1'b0, 26'h0);
    ev(1'b0, 1'b0, 1'b1, 26'h0);
    check(stream_mode, 2'h0);
    ev(1'b0, 1'b1, 1'b1, 26'h0);
    ev(1'b0, 1'b0, 1'b1, 26'h0);
    check(stream_mode, 2'h1);
    acc_chk(1'b0, 1'b1, 26'h1234, 2'h1);
    acc_chk(1'b0, 1'b0, 26'h1234, 2'h2);
    acc_chk(1'b1, 1'b1, 26'h1234, 2'h2);
    for (int n = 1; n <= 3; n++)
    begin
      ev(1'b1, 1'b0, 1'b1, 26'h2aaa);
      check({l3_stream_req, l2_stream_req}, {1'b0, n >= 3, 1'b0, n >= 2});
    end
    acc_chk(1'b0, 1'b0, 26'h2aaa, 2'h2);
    @(posedge clock);
    acc_valid <= 1'b0;
    #1 check(stream_mode, 2'h0);
    ev(1'b0, 1'b0, 1'b1, 26'h0);
    ev(1'b0, 1'b0, 1'b1, 26'h0);
    ev(1'b1, 1'b0, 1'b0, 26'h3);
    check(stream_mode, 2'h0);
    do_reset(1'b1);
    test_done();
  end
endmodule
